// [logic/bal_alu.sv]
// Purpose: byte arithmetic and logic unit with status flags for the core
// Assumes: decoder holds op_code and operands stable while op_valid is high
// Notes: byte ops answer one cycle after acceptance, word ops after two
`timescale 1ns/1ns
`default_nettype none

module bal_alu (
   input wire logic mclk,                         // core clock
   input wire logic sys_rst,                      // synchronous reset, active high
   input wire logic op_valid,                     // decoder presents an operation
   output logic op_ready,                         // unit can take an operation
   input wire bal_pkg::bal_op_type op_code,       // operation to run
   input wire logic [7:0] dst_data,               // destination or low byte of pair
   input wire logic [7:0] dst_hi_data,            // high byte of pair
   input wire logic [7:0] src_data,               // src_operand register
   input wire logic [7:0] imm_data,               // instruction constant
   input wire logic sreg_load,                    // core writes the status word
   input wire logic [7:0] sreg_wdata,             // status word to write
   output logic res_valid,                        // result pulse
   output logic res_word,                         // result is a register pair
   output logic [7:0] res_data,                   // result or low byte
   output logic [7:0] res_hi_data,                // high byte of pair result
   output logic [7:0] sreg_out                    // status word
);
   import bal_pkg::*;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_word(input bal_op_type op);
      is_word = (op == BAL_OP_WORD_ADD_IMM) || (op == BAL_OP_WORD_SUB_IMM);
   endfunction

   function automatic logic is_logic(input bal_op_type op);
      is_logic = (op == BAL_OP_REG_AND) || (op == BAL_OP_AND_IMM) || (op == BAL_OP_REG_OR)
                 || (op == BAL_OP_OR_IMM) || (op == BAL_OP_REG_BITWISE_XOR)
                 || (op == BAL_OP_MASK_SET_BITS) || (op == BAL_OP_MASK_CLEAR_BITS);
   endfunction

   // ----------------------------------------------------------------
   // state and holding registers
   // ----------------------------------------------------------------
   bal_state_type state_r, state_nxt;
   logic [7:0] hi_byte_r;
   logic [7:0] lo_res_r;
   logic carry_mid_r;
   logic word_sub_r;
   logic [7:0] sreg_r, sreg_nxt;
   logic res_valid_r;
   logic res_word_r;
   logic [7:0] res_data_r, res_data_nxt;
   logic [7:0] res_hi_r;
   logic accept;
   logic in_hi;

   // adder operands and outputs
   logic [7:0] add_a, add_b, add_sum;
   logic add_cin, add_sub, add_cout, add_half, add_ovf;
   logic [7:0] logic_res;
   logic res_zero;

   assign op_ready = (state_r == BAL_ST_IDLE);
   assign accept = op_valid && op_ready;
   assign in_hi = (state_r == BAL_ST_WORD_HI);

   // ----------------------------------------------------------------
   // operand steering for the shared adder
   // ----------------------------------------------------------------
   always_comb begin
      add_a = dst_data;
      add_b = src_data;
      add_cin = 1'b0;
      add_sub = 1'b0;
      if (in_hi) begin
         add_a = hi_byte_r;            // high byte ripples the low carry
         add_b = BAL_BYTE_ZERO;
         add_cin = carry_mid_r;
         add_sub = word_sub_r;
      end else begin
         case (op_code)
            BAL_OP_REG_ADD_CARRY: add_cin = sreg_r[BAL_FLAG_C];
            BAL_OP_WORD_ADD_IMM: add_b = imm_data;
            BAL_OP_REG_SUB: add_sub = 1'b1;
            BAL_OP_SUB_IMM: begin
               add_b = imm_data;
               add_sub = 1'b1;
            end
            BAL_OP_REG_SUB_BORROW: begin
               add_cin = sreg_r[BAL_FLAG_C];
               add_sub = 1'b1;
            end
            BAL_OP_SUB_IMM_BORROW: begin
               add_b = imm_data;
               add_cin = sreg_r[BAL_FLAG_C];
               add_sub = 1'b1;
            end
            BAL_OP_WORD_SUB_IMM: begin
               add_b = imm_data;
               add_sub = 1'b1;
            end
            BAL_OP_TWOS_NEGATE: begin
               add_a = BAL_BYTE_ZERO;
               add_b = dst_data;
               add_sub = 1'b1;
            end
            BAL_OP_INCREMENT: begin
               add_b = BAL_BYTE_ZERO;
               add_cin = 1'b1;
            end
            default: add_cin = 1'b0;
         endcase
      end
   end

   bal_addsub #(.WIDTH(BAL_DATA_W)) u_addsub (
      .a(add_a),
      .b(add_b),
      .cin(add_cin),
      .sub(add_sub),
      .sum(add_sum),
      .cout(add_cout),
      .half(add_half),
      .ovf(add_ovf)
   );

   // ----------------------------------------------------------------
   // bitwise results
   // ----------------------------------------------------------------
   always_comb begin
      case (op_code)
         BAL_OP_REG_AND: logic_res = dst_data & src_data;
         BAL_OP_AND_IMM: logic_res = dst_data & imm_data;
         BAL_OP_REG_OR: logic_res = dst_data | src_data;
         BAL_OP_OR_IMM: logic_res = dst_data | imm_data;
         BAL_OP_MASK_SET_BITS: logic_res = dst_data | imm_data;
         BAL_OP_MASK_CLEAR_BITS: logic_res = dst_data & (BAL_BYTE_ONES - imm_data);
         BAL_OP_REG_BITWISE_XOR: logic_res = dst_data ^ src_data;
         BAL_OP_ONES_COMPLEMENT: logic_res = BAL_BYTE_ONES - dst_data;
         default: logic_res = add_sum;
      endcase
   end

   // result byte for a single-cycle op or the low byte of a pair
   always_comb begin
      res_data_nxt = is_logic(op_code) || (op_code == BAL_OP_ONES_COMPLEMENT) ? logic_res : add_sum;
      res_zero = (res_data_nxt == BAL_BYTE_ZERO);
   end

   // ----------------------------------------------------------------
   // status word next value
   // ----------------------------------------------------------------
   always_comb begin
      sreg_nxt = sreg_r;
      if (in_hi) begin
         // pair flags from the high byte and the stored low byte
         sreg_nxt[BAL_FLAG_C] = add_cout;
         sreg_nxt[BAL_FLAG_Z] = (add_sum == BAL_BYTE_ZERO) && (lo_res_r == BAL_BYTE_ZERO);
         sreg_nxt[BAL_FLAG_N] = add_sum[BAL_DATA_W-1];
         sreg_nxt[BAL_FLAG_V] = add_ovf;
         sreg_nxt[BAL_FLAG_S] = add_sum[BAL_DATA_W-1] ^ add_ovf;
      end else if (accept && !is_word(op_code)) begin
         sreg_nxt[BAL_FLAG_Z] = res_zero;
         sreg_nxt[BAL_FLAG_N] = res_data_nxt[BAL_DATA_W-1];
         if (is_logic(op_code)) begin
            sreg_nxt[BAL_FLAG_V] = 1'b0;
         end else if (op_code == BAL_OP_ONES_COMPLEMENT) begin
            sreg_nxt[BAL_FLAG_V] = 1'b0;
            sreg_nxt[BAL_FLAG_C] = 1'b1;
         end else if (op_code == BAL_OP_INCREMENT) begin
            sreg_nxt[BAL_FLAG_V] = add_ovf;
         end else begin
            sreg_nxt[BAL_FLAG_V] = add_ovf;
            sreg_nxt[BAL_FLAG_C] = add_cout;
            sreg_nxt[BAL_FLAG_H] = add_half;
         end
         sreg_nxt[BAL_FLAG_S] = res_data_nxt[BAL_DATA_W-1] ^ sreg_nxt[BAL_FLAG_V];
      end else if (sreg_load) begin
         sreg_nxt = sreg_wdata;
      end
   end

   // status word register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sreg_r <= BAL_SREG_RESET;
      end else begin
         sreg_r <= sreg_nxt;
      end
   end

   // ----------------------------------------------------------------
   // sequencer for two-cycle pair operations
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BAL_ST_IDLE: if (accept && is_word(op_code)) state_nxt = BAL_ST_WORD_HI;
         BAL_ST_WORD_HI: state_nxt = BAL_ST_IDLE;
         default: state_nxt = BAL_ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r <= BAL_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // low byte and carry held across the pair operation
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hi_byte_r <= BAL_BYTE_ZERO;
         lo_res_r <= BAL_BYTE_ZERO;
         carry_mid_r <= 1'b0;
         word_sub_r <= 1'b0;
      end else if (accept && is_word(op_code)) begin
         hi_byte_r <= dst_hi_data;
         lo_res_r <= add_sum;
         carry_mid_r <= add_cout;
         word_sub_r <= (op_code == BAL_OP_WORD_SUB_IMM);
      end
   end

   // ----------------------------------------------------------------
   // result registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         res_valid_r <= 1'b0;
         res_word_r <= 1'b0;
         res_data_r <= BAL_BYTE_ZERO;
         res_hi_r <= BAL_BYTE_ZERO;
      end else if (in_hi) begin
         res_valid_r <= 1'b1;
         res_word_r <= 1'b1;
         res_data_r <= lo_res_r;
         res_hi_r <= add_sum;
      end else if (accept && !is_word(op_code)) begin
         res_valid_r <= 1'b1;
         res_word_r <= 1'b0;
         res_data_r <= res_data_nxt;
      end else begin
         res_valid_r <= 1'b0;
         res_word_r <= 1'b0;
      end
   end

   assign res_valid = res_valid_r;
   assign res_word = res_word_r;
   assign res_data = res_data_r;
   assign res_hi_data = res_hi_r;
   assign sreg_out = sreg_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   byte_latency_a: assert property (
      accept && !is_word(op_code) |=> res_valid && !res_word && op_ready)
      else $error("byte op result not one cycle after acceptance");

   word_latency_a: assert property (
      accept && is_word(op_code) |=> !res_valid && !op_ready ##1 res_valid && res_word)
      else $error("pair op result not two cycles after acceptance");

   add_carry_a: assert property (
      accept && op_code == BAL_OP_REG_ADD_CARRY |=>
      res_data == 8'($past(dst_data) + $past(src_data) + {7'h00, $past(sreg_r[BAL_FLAG_C])}))
      else $error("add with carry result wrong");

   word_add_a: assert property (
      accept && op_code == BAL_OP_WORD_ADD_IMM |-> ##2
      {res_hi_data, res_data} == 16'({$past(dst_hi_data, 2), $past(dst_data, 2)} + {8'h00, $past(imm_data, 2)}))
      else $error("pair add result wrong");

   sub_imm_a: assert property (
      accept && op_code == BAL_OP_SUB_IMM |=>
      res_data == 8'($past(dst_data) - $past(imm_data))
      && sreg_r[BAL_FLAG_C] == ($past(imm_data) > $past(dst_data)))
      else $error("subtract immediate result or borrow wrong");

   sub_borrow_a: assert property (
      accept && op_code == BAL_OP_REG_SUB_BORROW |=>
      res_data == 8'($past(dst_data) - $past(src_data) - {7'h00, $past(sreg_r[BAL_FLAG_C])}))
      else $error("subtract with borrow result wrong");

   imm_borrow_a: assert property (
      accept && op_code == BAL_OP_SUB_IMM_BORROW |=>
      res_data == 8'($past(dst_data) - $past(imm_data) - {7'h00, $past(sreg_r[BAL_FLAG_C])}))
      else $error("subtract immediate with borrow result wrong");

   word_sub_a: assert property (
      accept && op_code == BAL_OP_WORD_SUB_IMM |-> ##2
      {res_hi_data, res_data} == 16'({$past(dst_hi_data, 2), $past(dst_data, 2)} - {8'h00, $past(imm_data, 2)}))
      else $error("pair subtract result wrong");

   and_keeps_a: assert property (
      accept && op_code == BAL_OP_AND_IMM |=>
      $stable(sreg_r[BAL_FLAG_C]) && $stable(sreg_r[BAL_FLAG_H]) && !sreg_r[BAL_FLAG_V])
      else $error("and immediate disturbed carry or half-carry");

   or_imm_a: assert property (
      accept && op_code == BAL_OP_OR_IMM |=>
      res_data == ($past(dst_data) | $past(imm_data)) && $stable(sreg_r[BAL_FLAG_C]))
      else $error("or immediate result or flags wrong");

   set_bits_a: assert property (
      accept && op_code == BAL_OP_MASK_SET_BITS |=> (res_data & $past(imm_data)) == $past(imm_data))
      else $error("set bits left a masked bit clear");

   clear_bits_a: assert property (
      accept && op_code == BAL_OP_MASK_CLEAR_BITS |=>
      (res_data & $past(imm_data)) == BAL_BYTE_ZERO && sreg_r[BAL_FLAG_Z] == (res_data == BAL_BYTE_ZERO))
      else $error("clear bits left a masked bit set");

   negate_a: assert property (
      accept && op_code == BAL_OP_TWOS_NEGATE |=>
      res_data == 8'(BAL_BYTE_ZERO - $past(dst_data)) && sreg_r[BAL_FLAG_C] == (res_data != BAL_BYTE_ZERO))
      else $error("negate result or carry wrong");

   sign_flag_a: assert property (
      res_valid |-> sreg_r[BAL_FLAG_S] == (sreg_r[BAL_FLAG_N] ^ sreg_r[BAL_FLAG_V]))
      else $error("sign flag differs from negative xor overflow");

   cover_add_c: cover property (accept && op_code == BAL_OP_REG_ADD ##1 sreg_r[BAL_FLAG_C]);
   cover_word_c: cover property (accept && op_code == BAL_OP_WORD_SUB_IMM ##2 res_valid);
   cover_b2b_c: cover property (accept ##1 accept ##1 accept);
   cover_ovf_c: cover property (accept && op_code == BAL_OP_INCREMENT ##1 sreg_r[BAL_FLAG_V]);

endmodule // bal_alu

`default_nettype wire

// [logic/bal_pkg.sv]
// Purpose: shared constants and types for the byte arithmetic and logic unit
// Assumes: 8-bit data path, status word laid out as c,z,n,v,s,h,t,i from bit 0
// Notes: no timescale here, package only
`default_nettype none

package bal_pkg;

   // ----------------------------------------------------------------
   // widths and byte constants
   // ----------------------------------------------------------------
   localparam int BAL_DATA_W = 8;
   localparam int BAL_NIBBLE_W = 4;
   localparam logic [7:0] BAL_BYTE_ONES = 8'hff;
   localparam logic [7:0] BAL_BYTE_ZERO = 8'h00;
   localparam logic [7:0] BAL_BYTE_ONE = 8'h01;

   // ----------------------------------------------------------------
   // status word field positions and reset value
   // ----------------------------------------------------------------
   localparam int BAL_FLAG_C = 0;
   localparam int BAL_FLAG_Z = 1;
   localparam int BAL_FLAG_N = 2;
   localparam int BAL_FLAG_V = 3;
   localparam int BAL_FLAG_S = 4;
   localparam int BAL_FLAG_H = 5;
   localparam logic [7:0] BAL_SREG_RESET = 8'h00;

   // ----------------------------------------------------------------
   // operation timing in cycles
   // ----------------------------------------------------------------
   localparam int BAL_BYTE_CYCLES = 1;
   localparam int BAL_WORD_CYCLES = 2;

   // operation codes presented by the decoder
   typedef enum logic [4:0] {
      BAL_OP_REG_ADD = 5'h00,
      BAL_OP_REG_ADD_CARRY = 5'h01,
      BAL_OP_WORD_ADD_IMM = 5'h02,
      BAL_OP_REG_SUB = 5'h03,
      BAL_OP_SUB_IMM = 5'h04,
      BAL_OP_REG_SUB_BORROW = 5'h05,
      BAL_OP_SUB_IMM_BORROW = 5'h06,
      BAL_OP_WORD_SUB_IMM = 5'h07,
      BAL_OP_REG_AND = 5'h08,
      BAL_OP_AND_IMM = 5'h09,
      BAL_OP_REG_OR = 5'h0a,
      BAL_OP_OR_IMM = 5'h0b,
      BAL_OP_REG_BITWISE_XOR = 5'h0c,
      BAL_OP_ONES_COMPLEMENT = 5'h0d,
      BAL_OP_TWOS_NEGATE = 5'h0e,
      BAL_OP_MASK_SET_BITS = 5'h0f,
      BAL_OP_MASK_CLEAR_BITS = 5'h10,
      BAL_OP_INCREMENT = 5'h11
   } bal_op_type;

   // sequencer states, one-hot
   typedef enum logic [1:0] {
      BAL_ST_IDLE = 2'h1,
      BAL_ST_WORD_HI = 2'h2
   } bal_state_type;

endpackage : bal_pkg

`default_nettype wire

// [logic/bal_addsub.sv]
// Purpose: shared adder/subtractor with carry, half-carry and overflow
// Assumes: sub high means a - b - cin, cin then acts as a borrow
// Notes: carry and half-carry are reported as borrows when subtracting
`timescale 1ns/1ns
`default_nettype none

module bal_addsub #(
   parameter int WIDTH = bal_pkg::BAL_DATA_W
) (
   input wire logic [WIDTH-1:0] a,   // left operand
   input wire logic [WIDTH-1:0] b,   // right operand
   input wire logic cin,             // carry or borrow in
   input wire logic sub,             // subtract when high
   output logic [WIDTH-1:0] sum,     // result
   output logic cout,                // carry or borrow out
   output logic half,                // nibble carry or borrow
   output logic ovf                  // two's complement overflow
);
   import bal_pkg::*;

   logic [WIDTH-1:0] b_eff;
   logic c_eff;
   logic [WIDTH:0] full;
   logic [BAL_NIBBLE_W:0] low;

   // subtraction as a + ~b + ~borrow
   always_comb begin
      b_eff = sub ? ~b : b;
      c_eff = sub ? ~cin : cin;
      full = {1'b0, a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, c_eff};
      low = {1'b0, a[BAL_NIBBLE_W-1:0]} + {1'b0, b_eff[BAL_NIBBLE_W-1:0]}
            + {{BAL_NIBBLE_W{1'b0}}, c_eff};
      sum = full[WIDTH-1:0];
      cout = sub ? ~full[WIDTH] : full[WIDTH];
      half = sub ? ~low[BAL_NIBBLE_W] : low[BAL_NIBBLE_W];
      ovf = (a[WIDTH-1] == b_eff[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]);
   end

endmodule // bal_addsub

`default_nettype wire

// [verification/bal_core_model.sv]
// Purpose: core-side decoder model that offers operations to the unit
// Assumes: every call starts and ends at a falling clock edge
// Notes: operand lines carry scrambled values while nothing is offered
`timescale 1ns/1ns
`default_nettype none

module bal_core_model (
   input wire logic mclk,                  // core clock
   input wire logic op_ready,              // unit can take an operation
   output logic op_valid,                  // operation offered
   output bal_pkg::bal_op_type op_code,    // operation code
   output logic [7:0] dst_data,            // destination or low byte
   output logic [7:0] dst_hi_data,         // high byte of pair
   output logic [7:0] src_data,            // source register
   output logic [7:0] imm_data             // instruction constant
);
   import bal_pkg::*;

   // ----------------------------------------------------------------
   // request driving
   // ----------------------------------------------------------------
   // idle values from time zero
   initial begin
      op_valid = 1'b0;
      op_code = BAL_OP_REG_ADD;
      {dst_data, dst_hi_data, src_data, imm_data} = 32'h5a3c_c3a5;
   end

   // offer one operation and hold it until the edge that takes it
   task automatic issue(input bal_op_type op, input logic [7:0] d, dh, s, k);
      logic taken;
      op_valid = 1'b1;
      op_code = op;
      dst_data = d;
      dst_hi_data = dh;
      src_data = s;
      imm_data = k;
      // ready is read at the falling edge, where it is settled, never in the rising edge's time step
      taken = (op_ready === 1'b1);
      @(posedge mclk);
      while (!taken) begin
         @(negedge mclk);
         taken = (op_ready === 1'b1);
         @(posedge mclk);
      end
      @(negedge mclk);
   endtask

   // withdraw the request; stale operands must not look valid
   task automatic idle();
      op_valid = 1'b0;
      {dst_data, dst_hi_data, src_data, imm_data} = ~{dst_data, dst_hi_data, src_data, imm_data};
      @(negedge mclk);
   endtask
endmodule // bal_core_model

`default_nettype wire

// [verification/bal_alu_tb.sv]
// Purpose: self-checking bench for the byte arithmetic and logic unit
// Assumes: inputs change at the falling edge, results checked at the rising edge
// Notes: a reference model predicts result, flags and latency for every take
`timescale 1ns/1ns
`default_nettype none

module bal_alu_tb;
   import bal_pkg::*;

   // ----------------------------------------------------------------
   // signals and bookkeeping
   // ----------------------------------------------------------------
   logic mclk, sys_rst, op_valid, op_ready, sreg_load, res_valid, res_word;
   bal_op_type op_code;
   logic [7:0] dst_data, dst_hi_data, src_data, imm_data, sreg_wdata, res_data, res_hi_data, sreg_out;
   logic [7:0] exp_sreg;
   logic [31:0] lfsr;
   logic [31:0] r2;
   logic [24:0] q_val[$];
   int q_due[$];
   int err_count, checked, cyc;

   bal_alu dut (.mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid), .op_ready(op_ready),
      .op_code(op_code), .dst_data(dst_data), .dst_hi_data(dst_hi_data), .src_data(src_data),
      .imm_data(imm_data), .sreg_load(sreg_load), .sreg_wdata(sreg_wdata), .res_valid(res_valid),
      .res_word(res_word), .res_data(res_data), .res_hi_data(res_hi_data), .sreg_out(sreg_out));

   bal_core_model core (.mclk(mclk), .op_ready(op_ready), .op_valid(op_valid), .op_code(op_code),
      .dst_data(dst_data), .dst_hi_data(dst_hi_data), .src_data(src_data), .imm_data(imm_data));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return x[0] ? (x >> 1) ^ 32'h8020_0003 : x >> 1;
   endfunction

   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   // reference: {pair, high byte, low byte, status word}
   function automatic logic [24:0] model_op(input bal_op_type op, input logic [7:0] d, dh, s, k, sr);
      int a, b, r, ci;
      logic [7:0] f;
      logic w;
      f = sr;
      w = op inside {BAL_OP_WORD_ADD_IMM, BAL_OP_WORD_SUB_IMM};
      b = (op inside {BAL_OP_SUB_IMM, BAL_OP_SUB_IMM_BORROW, BAL_OP_AND_IMM, BAL_OP_OR_IMM,
         BAL_OP_MASK_SET_BITS, BAL_OP_MASK_CLEAR_BITS}) ? k : s;
      ci = (op inside {BAL_OP_REG_ADD_CARRY, BAL_OP_REG_SUB_BORROW, BAL_OP_SUB_IMM_BORROW}) ? sr[0] : 0;
      a = (op == BAL_OP_TWOS_NEGATE) ? 0 : d;
      b = (op == BAL_OP_TWOS_NEGATE) ? d : b;
      f[3] = 1'b0;
      case (op)
         BAL_OP_REG_ADD, BAL_OP_REG_ADD_CARRY: begin
            r = a + b + ci;
            f[0] = r > 255;
            f[5] = a % 16 + b % 16 + ci > 15;
            f[3] = a[7] == b[7] && r[7] != a[7];
         end
         BAL_OP_REG_SUB, BAL_OP_SUB_IMM, BAL_OP_REG_SUB_BORROW, BAL_OP_SUB_IMM_BORROW, BAL_OP_TWOS_NEGATE: begin
            r = a - b - ci;
            f[0] = a < b + ci;
            f[5] = a % 16 < b % 16 + ci;
            f[3] = a[7] != b[7] && r[7] != a[7];
         end
         BAL_OP_WORD_ADD_IMM: begin
            a = {dh, d};
            r = a + k;
            f[0] = r > 65535;
            f[3] = !a[15] && r[15];
         end
         BAL_OP_WORD_SUB_IMM: begin
            a = {dh, d};
            r = a - k;
            f[0] = a < k;
            f[3] = a[15] && !r[15];
         end
         BAL_OP_REG_AND, BAL_OP_AND_IMM: r = d & b;
         BAL_OP_REG_OR, BAL_OP_OR_IMM, BAL_OP_MASK_SET_BITS: r = d | b;
         BAL_OP_REG_BITWISE_XOR: r = d ^ b;
         BAL_OP_MASK_CLEAR_BITS: r = d & (8'hff - b);
         BAL_OP_ONES_COMPLEMENT: begin
            r = 8'hff - d;
            f[0] = 1'b1;
         end
         default: begin
            r = d + 1;
            f[3] = r == 128;
         end
      endcase
      r = w ? r & 16'hffff : r & 8'hff;
      f[1] = r == 0;
      f[2] = w ? r[15] : r[7];
      f[4] = f[2] ^ f[3];
      return {w, r[15:0], f};
   endfunction

   // status word load while the unit is idle
   task automatic load_sreg(input logic [7:0] v);
      while (op_ready !== 1'b1) @(negedge mclk);
      sreg_load = 1'b1;
      sreg_wdata = v;
      @(negedge mclk);
      sreg_load = 1'b0;
      sreg_wdata = ~v;
      check(sreg_out === v, "status load not shown");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock, watchdog and edge monitor
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // cut a hang short well beyond the expected run
   initial begin
      #(8 * 20000);
      err_count++;
      $display("Error at %0t: watchdog expired", $time);
      print_verdict();
   end

   // predict on every take, compare value and latency on every result
   always @(posedge mclk) begin
      logic [24:0] e;
      cyc++;
      if (!sys_rst && res_valid === 1'b1) begin
         if (q_val.size() == 0)
            check(1'b0, "unexpected result");
         else begin
            e = q_val.pop_front();
            check(q_due.pop_front() == cyc && res_word === e[24] && res_data === e[15:8] && sreg_out === e[7:0]
               && (!e[24] || res_hi_data === e[23:16]), "result or flags wrong");
         end
      end
      if (q_due.size() > 0 && q_due[0] <= cyc) begin
         check(1'b0, "result missing");
         void'(q_due.pop_front());
         void'(q_val.pop_front());
      end
      if (!sys_rst && op_valid === 1'b1 && op_ready === 1'b1) begin
         // a pair op leaves the status load of its taking edge in place, a byte op drops it
         e = model_op(op_code, dst_data, dst_hi_data, src_data, imm_data,
            (sreg_load === 1'b1 && op_code inside {BAL_OP_WORD_ADD_IMM, BAL_OP_WORD_SUB_IMM})
            ? sreg_wdata : exp_sreg);
         exp_sreg = e[7:0];
         q_val.push_back(e);
         q_due.push_back(cyc + (e[24] ? 2 : 1));
      end else if (!sys_rst && sreg_load === 1'b1 && op_ready === 1'b1)
         exp_sreg = sreg_wdata;
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      sreg_load = 1'b0;
      sreg_wdata = 8'h00;
      exp_sreg = BAL_SREG_RESET;
      lfsr = 32'hf789cff3;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      check(res_valid === 1'b0 && res_word === 1'b0 && res_data === 8'h00 && res_hi_data === 8'h00
         && sreg_out === 8'h00 && op_ready === 1'b1, "reset values");
      sys_rst = 1'b0;
      $display("test reset done");
      // boundary cases, back to back
      load_sreg(8'h01);
      core.issue(BAL_OP_REG_ADD_CARRY, 8'h0f, 8'h00, 8'h00, 8'h00);
      core.issue(BAL_OP_REG_ADD, 8'h7f, 8'h00, 8'h01, 8'h00);
      core.issue(BAL_OP_WORD_ADD_IMM, 8'hff, 8'hff, 8'h00, 8'h01);
      core.issue(BAL_OP_SUB_IMM, 8'h80, 8'h00, 8'h00, 8'h01);
      core.issue(BAL_OP_REG_SUB, 8'h10, 8'h00, 8'h11, 8'h00);
      core.issue(BAL_OP_REG_SUB_BORROW, 8'h00, 8'h00, 8'h00, 8'h00);
      core.issue(BAL_OP_SUB_IMM_BORROW, 8'h01, 8'h00, 8'h00, 8'h00);
      core.issue(BAL_OP_WORD_SUB_IMM, 8'h00, 8'h80, 8'h00, 8'h01);
      core.issue(BAL_OP_AND_IMM, 8'hf0, 8'h00, 8'h00, 8'h0f);
      core.issue(BAL_OP_OR_IMM, 8'h00, 8'h00, 8'h00, 8'h80);
      core.issue(BAL_OP_MASK_SET_BITS, 8'h01, 8'h00, 8'h00, 8'h40);
      core.issue(BAL_OP_MASK_CLEAR_BITS, 8'hff, 8'h00, 8'h00, 8'hff);
      core.issue(BAL_OP_TWOS_NEGATE, 8'h80, 8'h00, 8'h00, 8'h00);
      core.issue(BAL_OP_INCREMENT, 8'h7f, 8'h00, 8'h00, 8'h00);
      core.issue(BAL_OP_ONES_COMPLEMENT, 8'h55, 8'h00, 8'h00, 8'h00);
      // a status load alongside a byte operation loses to the flag update
      core.idle();
      sreg_load = 1'b1;
      sreg_wdata = 8'hff;
      core.issue(BAL_OP_REG_BITWISE_XOR, 8'h3c, 8'h00, 8'h3c, 8'h00);
      sreg_load = 1'b0;
      $display("test directed done");
      // random mix of every code, loads and gaps
      repeat (600) begin
         lfsr = lfsr_next(lfsr);
         r2 = lfsr_next(lfsr);
         if (lfsr[31:29] == 3'b000) begin
            core.idle();
            load_sreg(r2[31:24]);
         end else begin
            // status load beside the op: taken with a pair op, lost to a byte op
            sreg_load = r2[23];
            sreg_wdata = r2[31:24];
         end
         core.issue(bal_op_type'(5'(lfsr[20:16] % 5'd18)), lfsr[7:0], lfsr[15:8], r2[7:0], r2[15:8]);
         if (lfsr[28])
            core.idle();
         lfsr = r2;
      end
      core.idle();
      repeat (3) @(negedge mclk);
      check(q_val.size() == 0, "results outstanding");
      $display("test random done");
      print_verdict();
   end
endmodule // bal_alu_tb

`default_nettype wire
